// ==== hw/tor_consts.svh ====
// register offsets, field positions, reset values and mode codes of the timer output block
`ifndef TOR_CONSTS_SVH
`define TOR_CONSTS_SVH
`define TOR_A_MODE 6'h00
`define TOR_A_START 6'h04
`define TOR_A_IOCTL 6'h08
`define TOR_A_OLCTL 6'h0C
`define TOR_A_OUTEN 6'h10
`define TOR_A_PERIOD 6'h14
`define TOR_A_CMP0 6'h18
`define TOR_A_CMP1 6'h1C
`define TOR_A_CMP2 6'h20
`define TOR_A_CMP3 6'h24
`define TOR_A_COUNT 6'h28
`define TOR_A_PFSEL 6'h2C
`define TOR_A_PDIR 6'h30
`define TOR_A_PORT_OUTPUT_VALUE 6'h34
`define TOR_A_STAT 6'h38
`define TOR_MC_NORMAL 3'h0
`define TOR_MC_PWM1 3'h1
`define TOR_MC_PWM2 3'h2
`define TOR_MC_PHASE 3'h3
`define TOR_MC_COMP 3'h4
`define TOR_MC_RSYNC 3'h5
`define TOR_OL_P 0
`define TOR_OL_N 1
`define TOR_OL_CYC 2
`define TOR_CNT_RST 16'h0000
`define TOR_PER_RST 16'hFFFF
`define TOR_CMP_RST 16'hFFFF
`endif

// ==== hw/tor_pkg.sv ====
// types shared by the timer output block
package tor_pkg;
  typedef enum logic [5:0]
  {
    m_normal = 6'h01,
    m_pwm1 = 6'h02,
    m_pwm2 = 6'h04,
    m_phase = 6'h08,
    m_comp = 6'h10,
    m_rsync = 6'h20
  } tor_mode_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [5:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tor_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } tor_wb_rsp_t;
  typedef struct packed {
    logic [6:0] lvl;
    logic [6:0] oe_n;
  } tor_pin_t;
endpackage

// ==== hw/tor_cnt.sv ====
// timer counter: sawtooth, triangle or quadrature counting
`timescale 1ns/10ps
`include "tor_consts.svh"
module tor_cnt import tor_pkg::*;
#(
  parameter int CW = 16
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic tri_i,
  input wire logic wrap_i,
  input wire logic phase_i,
  input wire logic ph_a_i,
  input wire logic ph_b_i,
  input wire logic ld_i,
  input wire logic [CW-1:0] ld_val_i,
  input wire logic [CW-1:0] period_i,
  output logic [CW-1:0] cnt_o,
  output logic down_o
);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic down_reg;
  logic down_next;
  logic pha_reg;
  wire ph_rise = ph_a_i & ~pha_reg;
  wire at_top = cnt_reg == period_i;
  wire at_zero = cnt_reg == '0;
  wire [CW-1:0] cnt_inc = cnt_reg + CW'(1);
  wire [CW-1:0] cnt_dec = cnt_reg - CW'(1);

  // a stopped counter holds its value, so a restart resumes where it left off
  always_comb
  begin
    cnt_next = cnt_reg;
    down_next = down_reg;
    if (ld_i)
      cnt_next = ld_val_i;
    else if (run_i)
    begin
      if (phase_i)
      begin
        if (ph_rise)
          cnt_next = ph_b_i ? cnt_dec : cnt_inc;
      end
      else if (tri_i)
      begin
        if (down_reg ? at_zero : at_top)
          down_next = ~down_reg;
        cnt_next = (down_reg ^ (down_reg ? at_zero : at_top)) ? cnt_dec : cnt_inc;
      end
      else
      begin
        down_next = 1'b0;
        cnt_next = (wrap_i && at_top) ? '0 : cnt_inc;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= `TOR_CNT_RST;
      down_reg <= 1'b0;
      pha_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      down_reg <= down_next;
      pha_reg <= ph_a_i;
    end
  end

  assign cnt_o = cnt_reg;
  assign down_o = down_reg;

  a_hold_stopped: assert property (@(posedge clk_i) disable iff (rst_i)
    !run_i && !ld_i |=> $stable(cnt_o))
    else $error("counter moved while stopped");
  a_tri_turn: assert property (@(posedge clk_i) disable iff (rst_i)
    run_i && tri_i && !phase_i && !ld_i && !down_o && at_top && !at_zero
    |=> down_o && cnt_o == $past(cnt_o) - CW'(1))
    else $error("triangle count did not turn at the top");
endmodule

// ==== hw/tor_out_ctrl.sv ====
// timer waveform outputs with mode-change recovery levels and port muxing
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
// What this block does
// - reset: timer outputs low, pins high-impedance
// - PWM 1 drives no waveform on B/D
// - stopping complementary PWM gives its initial levels
// - stopping reset-sync PWM gives its initial levels
// - complementary to normal when stopped: all low
// - complementary to PWM 1 when stopped: low
// - reset-sync to normal/PWM 1: positive low, negative high, except pin 3 (D) low in PWM 1
// - reset-sync to complementary: cyclic pin low
// - complementary restart resumes held cycle and duty
// - complementary waveform changes at compare matches
// - reset-sync waveform changes at compare matches
// - normal/phase: match sets chosen I/O level
module tor_out_ctrl import tor_pkg::*;
#(
  parameter int CW = 16
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire tor_wb_req_t wb_i,
  output tor_wb_rsp_t wb_o,
  input wire logic ph_a_i,
  input wire logic ph_b_i,
  output tor_pin_t pin_o,
  output logic [6:0] wave_o
);
`include "tor_consts.svh"

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
      if (s[b])
        r[8*b +: 8] = d[8*b +: 8];
    return r;
  endfunction

  // unknown mode codes leave the mode unchanged
  function automatic tor_mode_t dec_mode(input logic [2:0] c, input tor_mode_t cur);
    case (c)
      `TOR_MC_NORMAL: return m_normal;
      `TOR_MC_PWM1: return m_pwm1;
      `TOR_MC_PWM2: return m_pwm2;
      `TOR_MC_PHASE: return m_phase;
      `TOR_MC_COMP: return m_comp;
      `TOR_MC_RSYNC: return m_rsync;
      default: return cur;
    endcase
  endfunction

  function automatic logic [2:0] enc_mode(input tor_mode_t m);
    unique case (m)
      m_normal: return `TOR_MC_NORMAL;
      m_pwm1: return `TOR_MC_PWM1;
      m_pwm2: return `TOR_MC_PWM2;
      m_phase: return `TOR_MC_PHASE;
      m_comp: return `TOR_MC_COMP;
      m_rsync: return `TOR_MC_RSYNC;
    endcase
  endfunction

  // ****************************************
  // registers and bus decode
  // ****************************************
  tor_mode_t mode_reg;
  logic start_reg;
  logic [7:0] io_reg;
  logic [2:0] ol_reg;
  logic [6:0] oen_reg;
  logic [6:0] pfs_reg;
  logic [6:0] pdir_reg;
  logic [6:0] port_output_value_reg;
  logic [CW-1:0] per_reg;
  logic [CW-1:0] cmp_reg [4];
  logic [6:0] wave_reg;
  logic [6:0] wave_next;
  tor_pin_t pin_reg;
  tor_pin_t pin_next;
  tor_wb_rsp_t rsp_reg;
  logic [CW-1:0] cnt;
  logic down;
  logic [3:0] mt;
  logic [3:0] hit_cmp;

  wire req = wb_i.cyc & wb_i.stb;
  // a write lands on the edge where the master samples ack
  wire wr = req & wb_i.we & rsp_reg.ack;
  wire hit_mode = wb_i.adr == `TOR_A_MODE;
  wire hit_start = wb_i.adr == `TOR_A_START;
  wire hit_io = wb_i.adr == `TOR_A_IOCTL;
  wire hit_ol = wb_i.adr == `TOR_A_OLCTL;
  wire hit_oen = wb_i.adr == `TOR_A_OUTEN;
  wire hit_per = wb_i.adr == `TOR_A_PERIOD;
  wire hit_cnt = wb_i.adr == `TOR_A_COUNT;
  wire hit_pfs = wb_i.adr == `TOR_A_PFSEL;
  wire hit_pdir = wb_i.adr == `TOR_A_PDIR;
  wire hit_port_output_value = wb_i.adr == `TOR_A_PORT_OUTPUT_VALUE;
  wire hit_stat = wb_i.adr == `TOR_A_STAT;
  assign hit_cmp[0] = wb_i.adr == `TOR_A_CMP0;
  assign hit_cmp[1] = wb_i.adr == `TOR_A_CMP1;
  assign hit_cmp[2] = wb_i.adr == `TOR_A_CMP2;
  assign hit_cmp[3] = wb_i.adr == `TOR_A_CMP3;

  wire [31:0] mode_w = wmerge(32'(enc_mode(mode_reg)), wb_i.dat, wb_i.sel);
  wire [31:0] start_w = wmerge(32'(start_reg), wb_i.dat, wb_i.sel);
  wire [31:0] io_w = wmerge(32'(io_reg), wb_i.dat, wb_i.sel);
  wire tor_mode_t mode_new = dec_mode(mode_w[2:0], mode_reg);
  wire mode_wr = wr & hit_mode;
  wire io_wr = wr & hit_io;
  wire stop_evt = wr & hit_start & start_reg & ~start_w[0];
  wire is_pwm3 = (mode_reg == m_comp) || (mode_reg == m_rsync);
  wire new_plain = (mode_new == m_normal) || (mode_new == m_pwm1);
  wire at_top = cnt == per_reg;
  wire at_zero = cnt == '0;
  wire [6:0] init_lv = {1'b0, {3{~ol_reg[`TOR_OL_N]}}, {3{~ol_reg[`TOR_OL_P]}}};
  wire [6:0] en_mask = is_pwm3 ? oen_reg : 7'h7F;

  // compare matches exist only while counting
  generate
    for (genvar g = 0; g < 4; g++)
    begin : g_match
      assign mt[g] = start_reg && (cnt == cmp_reg[g]);
    end
  endgenerate

  wire [CW-1:0] cmp_rd = hit_cmp[0] ? cmp_reg[0] : hit_cmp[1] ? cmp_reg[1] :
                         hit_cmp[2] ? cmp_reg[2] : cmp_reg[3];
  wire [31:0] rd = hit_mode ? 32'(enc_mode(mode_reg)) :
                   hit_start ? 32'(start_reg) :
                   hit_io ? 32'(io_reg) :
                   hit_ol ? 32'(ol_reg) :
                   hit_oen ? 32'(oen_reg) :
                   hit_per ? 32'(per_reg) :
                   (|hit_cmp) ? 32'(cmp_rd) :
                   hit_cnt ? 32'(cnt) :
                   hit_pfs ? 32'(pfs_reg) :
                   hit_pdir ? 32'(pdir_reg) :
                   hit_port_output_value ? 32'(port_output_value_reg) :
                   hit_stat ? 32'({down, wave_reg}) : 32'h0000_0000;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rsp_reg <= '0;
    else
    begin
      rsp_reg.ack <= req & ~rsp_reg.ack;
      rsp_reg.dat <= req ? rd : 32'h0000_0000;
    end
  end

  // cycle and duty survive a stop; only software rewrites them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_reg <= m_normal;
      start_reg <= 1'b0;
      io_reg <= 8'h00;
      ol_reg <= 3'h0;
      oen_reg <= 7'h00;
      per_reg <= `TOR_PER_RST;
      pfs_reg <= 7'h00;
      pdir_reg <= 7'h00;
      port_output_value_reg <= 7'h00;
      for (int i = 0; i < 4; i++)
        cmp_reg[i] <= `TOR_CMP_RST;
    end
    else if (wr)
    begin
      if (hit_mode)
        mode_reg <= mode_new;
      if (hit_start)
        start_reg <= start_w[0];
      if (hit_io)
        io_reg <= io_w[7:0];
      if (hit_ol)
        ol_reg <= 3'(wmerge(32'(ol_reg), wb_i.dat, wb_i.sel));
      if (hit_oen)
        oen_reg <= 7'(wmerge(32'(oen_reg), wb_i.dat, wb_i.sel));
      if (hit_per)
        per_reg <= CW'(wmerge(32'(per_reg), wb_i.dat, wb_i.sel));
      if (hit_pfs)
        pfs_reg <= 7'(wmerge(32'(pfs_reg), wb_i.dat, wb_i.sel));
      if (hit_pdir)
        pdir_reg <= 7'(wmerge(32'(pdir_reg), wb_i.dat, wb_i.sel));
      if (hit_port_output_value)
        port_output_value_reg <= 7'(wmerge(32'(port_output_value_reg), wb_i.dat, wb_i.sel));
      for (int i = 0; i < 4; i++)
        if (hit_cmp[i])
          cmp_reg[i] <= CW'(wmerge(32'(cmp_reg[i]), wb_i.dat, wb_i.sel));
    end
  end

  tor_cnt #(.CW(CW)) u_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(start_reg),
    .tri_i(mode_reg == m_comp),
    .wrap_i(mode_reg != m_normal),
    .phase_i(mode_reg == m_phase),
    .ph_a_i(ph_a_i),
    .ph_b_i(ph_b_i),
    .ld_i(wr & hit_cnt),
    .ld_val_i(CW'(wmerge(32'(cnt), wb_i.dat, wb_i.sel))),
    .period_i(per_reg),
    .cnt_o(cnt),
    .down_o(down)
  );

  // ****************************************
  // waveform levels
  // ****************************************
  // pins 0..3 are channel A..D; in the three-phase modes 0..2 are positive,
  // 3..5 negative and 6 is the cyclic output
  always_comb
  begin
    wave_next = wave_reg;
    if (io_wr)
      for (int i = 0; i < 4; i++)
        wave_next[i] = io_w[2*i];
    if (stop_evt && is_pwm3)
      wave_next = init_lv;
    else if (mode_wr && !start_reg)
    begin
      if (mode_reg == m_comp && new_plain)
        wave_next = 7'h00;
      if (mode_reg == m_rsync && new_plain)
        wave_next = 7'h38;
      if (mode_reg == m_rsync && mode_new == m_comp)
        wave_next[6] = 1'b0;
    end
    else if (start_reg)
    begin
      unique case (mode_reg)
        m_normal, m_phase:
          for (int i = 0; i < 4; i++)
            if (mt[i])
              wave_next[i] = io_reg[2*i+1];
        m_pwm1:
          for (int i = 0; i < 4; i += 2)
          begin
            if (mt[i])
              wave_next[i] = io_reg[2*i+1];
            if (mt[i+1])
              wave_next[i] = io_reg[2*i];
          end
        m_pwm2:
          for (int i = 1; i < 4; i++)
          begin
            if (at_top)
              wave_next[i] = io_reg[2*i];
            if (mt[i])
              wave_next[i] = io_reg[2*i+1];
          end
        m_comp:
        begin
          for (int i = 0; i < 3; i++)
            if (mt[i])
            begin
              wave_next[i] = down ^ ol_reg[`TOR_OL_P];
              wave_next[i+3] = ~down ^ ol_reg[`TOR_OL_N];
            end
          if (ol_reg[`TOR_OL_CYC] && at_top)
            wave_next[6] = 1'b1;
          if (ol_reg[`TOR_OL_CYC] && at_zero)
            wave_next[6] = 1'b0;
        end
        m_rsync:
        begin
          if (at_top)
            wave_next = {ol_reg[`TOR_OL_CYC], {3{~ol_reg[`TOR_OL_N]}},
                         {3{ol_reg[`TOR_OL_P]}}};
          for (int i = 0; i < 3; i++)
            if (mt[i])
            begin
              wave_next[i] = ~ol_reg[`TOR_OL_P];
              wave_next[i+3] = ol_reg[`TOR_OL_N];
            end
          if (mt[0])
            wave_next[6] = 1'b0;
        end
      endcase
    end
    // cycle-register pins carry no waveform
    if (mode_reg == m_pwm1)
    begin
      wave_next[1] = 1'b0;
      wave_next[3] = 1'b0;
    end
    if (mode_reg == m_pwm2)
      wave_next[0] = 1'b0;
  end

  // port mux: unassigned pins float until software picks timer or port
  assign pin_next.lvl = (pfs_reg & wave_next & en_mask) | (~pfs_reg & port_output_value_reg);
  assign pin_next.oe_n = ~(pfs_reg | pdir_reg);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wave_reg <= 7'h00;
      pin_reg <= '{lvl: 7'h00, oe_n: 7'h7F};
    end
    else
    begin
      wave_reg <= wave_next;
      pin_reg <= pin_next;
    end
  end

  assign wave_o = wave_reg;
  assign pin_o = pin_reg;
  assign wb_o = rsp_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_stop_comp;
    stop_evt && mode_reg == m_comp;
  endsequence
  sequence s_stop_rs;
    stop_evt && mode_reg == m_rsync;
  endsequence

  a_reset_low: assert property (disable iff (1'b0) rst_i |=>
    wave_o == 7'h00 && pin_o.oe_n == 7'h7F)
    else $error("reset did not park the outputs");
  a_pwm1_bd: assert property (mode_reg == m_pwm1 && $past(mode_reg) == m_pwm1
    |-> wave_o[1] == 1'b0 && wave_o[3] == 1'b0)
    else $error("waveform on B or D in PWM mode 1");
  a_comp_stop: assert property (s_stop_comp |=> wave_o == $past(init_lv))
    else $error("complementary stop level wrong");
  a_rs_stop: assert property (s_stop_rs |=> wave_o == $past(init_lv))
    else $error("reset-sync stop level wrong");
  a_comp_exit: assert property (mode_wr && !start_reg && mode_reg == m_comp &&
    new_plain |=> wave_o == 7'h00 ##1 mode_reg != m_comp)
    else $error("leaving complementary mode left outputs high");
  a_rs_exit: assert property (s_stop_rs ##[1:300] (mode_wr && new_plain)
    |=> wave_o[5:0] == 6'h38)
    else $error("leaving reset-sync mode gave wrong phases");
  a_rs_comp: assert property (mode_wr && !start_reg && mode_reg == m_rsync &&
    mode_new == m_comp |=> wave_o[6] == 1'b0 && mode_reg == m_comp)
    else $error("cyclic pin not low entering complementary mode");
  a_match_lvl: assert property (start_reg && mode_reg == m_normal && mt[0] &&
    !wr |=> wave_o[0] == $past(io_reg[1]))
    else $error("compare match level not applied");
  a_rs_top: assert property (start_reg && mode_reg == m_rsync && at_top &&
    !wr && !(|mt[2:0]) |=> wave_o[2:0] == {3{$past(ol_reg[`TOR_OL_P])}})
    else $error("reset-sync phases not active at counter reset");
  a_bus_ack: assert property (req && !rsp_reg.ack |=> wb_o.ack ##1 !wb_o.ack)
    else $error("bus ack not a single cycle after request");
  a_hold_duty: assert property (!start_reg && !wr |=> $stable(cmp_reg[0]) &&
    $stable(per_reg))
    else $error("duty or cycle changed while stopped");
endmodule

// ==== sim/tor_stage_model.sv ====
// power stage model driven by the timer output pins
`timescale 1ns/10ps
module tor_stage_model import tor_pkg::*;
(
  input wire tor_pin_t pin_i,
  output logic [6:0] gate_o
);
  // gate inputs carry pull-downs, so a pin that is not driven reads low
  assign gate_o = pin_i.lvl & ~pin_i.oe_n;
endmodule

// ==== sim/tor_out_ctrl_test.sv ====
// self-checking bench for the timer output block
`timescale 1ns/10ps
`include "tor_consts.svh"
module tor_out_ctrl_test import tor_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  tor_wb_req_t wb_i = '0;
  tor_wb_rsp_t wb_o;
  logic ph_a_i = 1'b0;
  logic ph_b_i = 1'b0;
  tor_pin_t pin_o;
  logic [6:0] wave_o;
  logic [6:0] gate;
  logic [63:0] exp_q[$];
  int n_fail = 0;
  int n_tests = 0;
  logic [31:0] q;
  logic [15:0] per;
  logic [15:0] cv;
  int i;

  tor_out_ctrl #(.CW(16)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
    .ph_a_i(ph_a_i), .ph_b_i(ph_b_i), .pin_o(pin_o), .wave_o(wave_o));
  tor_stage_model stage (.pin_i(pin_o), .gate_o(gate));

  initial
  begin
    forever #4 clk_i = ~clk_i;
  end

  // ****************
  // checking helpers
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one classic cycle; the request is held until ack is sampled high
  // no cycle count is assumed here; a lost ack is caught by the watchdog
  task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do
      @(posedge clk_i);
    while (wb_o.ack !== 1'b1);
    q = wb_o.dat;
    wb_i <= '0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({e, m});
    bus(1'b0, a, 32'h0);
  endtask

  // reads results as they appear and matches them against the oldest note
  always @(posedge clk_i)
  begin
    if (wb_o.ack === 1'b1 && wb_i.we === 1'b0 && exp_q.size() > 0)
    begin
      chk(wb_o.dat & exp_q[0][31:0], exp_q[0][63:32]);
      void'(exp_q.pop_front());
    end
  end

  // pin select and enable writes reach the pins one edge after the ack edge
  task automatic pins(input logic [6:0] m, input logic [6:0] lv, input logic [6:0] oe);
    @(posedge clk_i);
    @(negedge clk_i);
    chk(pin_o.lvl & m, lv);
    chk(pin_o.oe_n & m, oe);
  endtask

  // the waveform must move away from its first sampled value while running
  task automatic poll();
    int k;
    logic moved;
    logic [6:0] first;
    moved = 1'b0;
    bus(1'b0, `TOR_A_STAT, 32'h0);
    first = q[6:0];
    for (k = 0; k < 40; k++)
    begin
      bus(1'b0, `TOR_A_STAT, 32'h0);
      moved = moved | (q[6:0] !== first);
    end
    chk(moved, 1'b1);
  endtask

  task automatic quad(input logic dir, input int n);
    int k;
    ph_b_i <= dir;
    for (k = 0; k < n; k++)
    begin
      repeat (4) @(posedge clk_i);
      ph_a_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      ph_a_i <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    end_sim();
  end

  // ****************
  // main sequence
  // ****************
  initial
  begin
    void'($urandom(17));
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk(wave_o, 7'h00);
    chk(pin_o.oe_n, 7'h7F);
    chk(gate, 7'h00);
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`TOR_A_PERIOD, 32'hFFFF, 32'hFFFFFFFF);
    rd(6'h3C, 32'h0, 32'hFFFFFFFF);
    cv = 16'($urandom_range(20, 4));
    wr(`TOR_A_IOCTL, 32'h55);
    for (i = 0; i < 4; i++)
      wr(`TOR_A_CMP0 + 6'(4 * i), 32'(cv + 16'(i)));
    wr(`TOR_A_PFSEL, 32'h0F);
    pins(7'h0F, 7'h0F, 7'h00);
    wr(`TOR_A_START, 32'h1);
    repeat (40) @(posedge clk_i);
    rd(`TOR_A_STAT, 32'h0, 32'h0F);
    pins(7'h0F, 7'h00, 7'h00);
    wr(`TOR_A_PDIR, 32'h0F);
    wr(`TOR_A_PORT_OUTPUT_VALUE, 32'h0F);
    wr(`TOR_A_PFSEL, 32'h0);
    pins(7'h0F, 7'h0F, 7'h00);
    chk(gate & 7'h0F, 7'h0F);
    wr(`TOR_A_START, 32'h0);
    wr(`TOR_A_COUNT, 32'h123);
    repeat (10) @(posedge clk_i);
    rd(`TOR_A_COUNT, 32'h123, 32'hFFFF);
    wr(`TOR_A_MODE, 32'h3);
    wr(`TOR_A_IOCTL, 32'h1);
    wr(`TOR_A_CMP0, 32'h3);
    wr(`TOR_A_COUNT, 32'h0);
    wr(`TOR_A_PFSEL, 32'h0F);
    wr(`TOR_A_START, 32'h1);
    quad(1'b0, 4);
    rd(`TOR_A_COUNT, 32'h4, 32'hFFFF);
    rd(`TOR_A_STAT, 32'h0, 32'h1);
    quad(1'b1, 2);
    rd(`TOR_A_COUNT, 32'h2, 32'hFFFF);
    wr(`TOR_A_START, 32'h0);
    // same phase mode again: the mode write is skipped
    wr(`TOR_A_IOCTL, 32'h1);
    wr(`TOR_A_PFSEL, 32'h0F);
    wr(`TOR_A_START, 32'h1);
    quad(1'b0, 1);
    rd(`TOR_A_COUNT, 32'h3, 32'hFFFF);
    rd(`TOR_A_STAT, 32'h0, 32'h1);
    wr(`TOR_A_START, 32'h0);
    wr(`TOR_A_MODE, 32'h1);
    wr(`TOR_A_IOCTL, 32'h55);
    rd(`TOR_A_STAT, 32'h5, 32'hF);
    wr(`TOR_A_MODE, 32'h6);
    rd(`TOR_A_MODE, 32'h1, 32'h7);
    // three-phase setup goes through normal mode first
    per = 16'($urandom_range(30, 16));
    cv = 16'($urandom_range(12, 4));
    wr(`TOR_A_MODE, 32'h0);
    wr(`TOR_A_PERIOD, 32'(per));
    for (i = 0; i < 3; i++)
      wr(`TOR_A_CMP0 + 6'(4 * i), 32'(cv));
    wr(`TOR_A_OUTEN, 32'h0);
    wr(`TOR_A_OLCTL, 32'h4);
    wr(`TOR_A_MODE, 32'h4);
    wr(`TOR_A_OUTEN, 32'h7F);
    wr(`TOR_A_PDIR, 32'h0);
    wr(`TOR_A_PFSEL, 32'h7F);
    wr(`TOR_A_START, 32'h1);
    poll();
    wr(`TOR_A_START, 32'h0);
    rd(`TOR_A_STAT, 32'h3F, 32'h7F);
    pins(7'h7F, 7'h3F, 7'h00);
    wr(`TOR_A_OUTEN, 32'h0);
    pins(7'h7F, 7'h00, 7'h00);
    wr(`TOR_A_OUTEN, 32'h7F);
    rd(`TOR_A_PERIOD, 32'(per), 32'hFFFF);
    rd(`TOR_A_CMP1, 32'(cv), 32'hFFFF);
    wr(`TOR_A_START, 32'h1);
    poll();
    wr(`TOR_A_START, 32'h0);
    wr(`TOR_A_MODE, 32'h1);
    rd(`TOR_A_STAT, 32'h0, 32'h7F);
    wr(`TOR_A_MODE, 32'h4);
    wr(`TOR_A_START, 32'h1);
    wr(`TOR_A_START, 32'h0);
    wr(`TOR_A_MODE, 32'h0);
    rd(`TOR_A_STAT, 32'h0, 32'h7F);
    wr(`TOR_A_OUTEN, 32'h0);
    wr(`TOR_A_MODE, 32'h5);
    wr(`TOR_A_OUTEN, 32'h7F);
    wr(`TOR_A_START, 32'h1);
    poll();
    for (i = 0; i < 2; i++)
    begin
      wr(`TOR_A_START, 32'h0);
      rd(`TOR_A_STAT, 32'h3F, 32'h7F);
      wr(`TOR_A_MODE, 32'(i));
      // in PWM 1 pin 3 is the D pin, which carries no timer level
      rd(`TOR_A_STAT, (i == 0) ? 32'h38 : 32'h30, 32'h7F);
      wr(`TOR_A_MODE, 32'h5);
      wr(`TOR_A_PFSEL, 32'h7F);
      wr(`TOR_A_START, 32'h1);
      poll();
    end
    wr(`TOR_A_START, 32'h0);
    wr(`TOR_A_MODE, 32'h4);
    rd(`TOR_A_STAT, 32'h0, 32'h40);
    end_sim();
  end
endmodule
